// *** hw/reset_controller_regs.sv ***
/*
 * Reset controller: keyed command register, status and mode registers, reset
 * sequencer for software, watchdog, brownout and pin resets, and the open-drain
 * external reset pin driver.
 * Assumes all inputs, the slow clock level among them, are synchronous to clk;
 * backup_reset clears the mode register and reports a general reset, rst does not
 * touch the mode register and reports a wake-up reset.
 */
`timescale 1ns/1ps
`include "reset_controller_map.svh"

module reset_controller_regs #(
	parameter int ADDR_W = 5,
	parameter int LEN_W = 4
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic backup_reset,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Slow clock level and reset sources
	input wire logic slow_clock,
	input wire logic brownout_n,
	input wire logic bod_reset_enable,
	input wire logic watchdog_fault,
	input wire logic watchdog_proc_only,
	// External reset pin, open drain
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	// Reset lines and interrupt
	output logic cpu_reset,
	output logic periph_reset,
	output logic irq
);

	localparam int EXT_W = (1 << LEN_W) + 1;

	reset_controller_pkg::seq_state_e state;
	reset_controller_pkg::seq_state_e next_state;
	reset_controller_pkg::reset_cause_e cause;
	reset_controller_pkg::mode_s mode;
	reset_controller_pkg::reset_lines_s soft_sel;
	reset_controller_pkg::reset_lines_s next_lines;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic wd_proc;
	logic slow_prev;
	logic slow_tick;
	logic pin_level;
	logic pin_prev;
	logic bo_level;
	logic bo_prev;
	logic pin_fall_ev;
	logic bo_fall_ev;
	logic pin_fall_flag;
	logic brownout_flag;
	logic [1:0] snap_flags;
	logic pin_self;
	logic [EXT_W-1:0] ext_cnt;
	logic [EXT_W-1:0] next_ext_cnt;
	logic start_ext;
	logic [`RC_EV_W-1:0] irq_status;
	logic [`RC_EV_W-1:0] irq_mask;
	logic [`RC_EV_W-1:0] irq_events;
	logic busy;
	logic wr_acc;
	logic rd_acc;
	logic rd_cap;
	logic key_ok;
	logic cmd_any;
	logic status_rd;
	logic leaving;
	logic [31:0] next_readdata;

	// Bus handshake: one wait cycle, then the access completes
	always_ff @(posedge clk) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	assign wr_acc = write && !waitrequest;
	assign rd_acc = read && !waitrequest;
	assign rd_cap = read && waitrequest;
	assign key_ok = (writedata[`RC_KEY_MSB:`RC_KEY_LSB] == `RC_KEY_VALUE) &&
		(byteenable == 4'hf);
	assign busy = (state == reset_controller_pkg::ST_SOFT);
	assign cmd_any = wr_acc && (address == `RC_CMD_OFS) && key_ok && !busy &&
		(writedata[`RC_CMD_CPU_BIT] || writedata[`RC_CMD_PERIPH_BIT] ||
		writedata[`RC_CMD_PIN_BIT]);
	assign status_rd = rd_acc && (address == `RC_STATUS_OFS);

	// Input sampling and edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			slow_prev <= 1'b0;
			pin_level <= 1'b1;
			pin_prev <= 1'b1;
			bo_level <= 1'b1;
			bo_prev <= 1'b1;
		end else begin
			slow_prev <= slow_clock;
			pin_level <= pin_in;
			pin_prev <= pin_level;
			bo_level <= brownout_n;
			bo_prev <= bo_level;
		end
	end

	assign slow_tick = slow_clock && !slow_prev;
	assign pin_fall_ev = pin_prev && !pin_level;
	assign bo_fall_ev = bo_prev && !bo_level;
	assign leaving = slow_tick && (cnt == 2'(`RC_HOLD_SLOW - 1));

	// Sequencer next state, highest priority source first
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (bod_reset_enable && !bo_level) begin
			next_state = reset_controller_pkg::ST_BROWN;
			next_cnt = 2'h0;
		end else if (watchdog_fault && state != reset_controller_pkg::ST_WDOG &&
			state != reset_controller_pkg::ST_USER &&
			state != reset_controller_pkg::ST_BROWN) begin
			next_state = reset_controller_pkg::ST_WDOG;
			next_cnt = 2'h0;
		end else begin
			unique case (state)
				reset_controller_pkg::ST_IDLE: begin
					if (cmd_any) begin
						next_state = reset_controller_pkg::ST_SOFT;
						next_cnt = 2'h0;
					end else if (mode.pin_reset_enable && !pin_level && !pin_self) begin
						next_state = reset_controller_pkg::ST_USER;
						next_cnt = 2'h0;
					end
				end
				reset_controller_pkg::ST_USER: begin
					if (!pin_level) begin
						next_cnt = 2'h0;
					end else if (leaving) begin
						next_state = reset_controller_pkg::ST_IDLE;
						next_cnt = 2'h0;
					end else if (slow_tick) begin
						next_cnt = cnt + 2'h1;
					end
				end
				default: begin
					if (leaving) begin
						next_state = reset_controller_pkg::ST_IDLE;
						next_cnt = 2'h0;
					end else if (slow_tick) begin
						next_cnt = cnt + 2'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			state <= reset_controller_pkg::ST_IDLE;
			cnt <= 2'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Latched selections of the running command or watchdog reset
	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			soft_sel <= '0;
			wd_proc <= 1'b0;
		end else begin
			if (state == reset_controller_pkg::ST_IDLE && cmd_any) begin
				soft_sel.cpu <= writedata[`RC_CMD_CPU_BIT];
				soft_sel.periph <= writedata[`RC_CMD_PERIPH_BIT];
			end
			if (next_state == reset_controller_pkg::ST_WDOG &&
				state != reset_controller_pkg::ST_WDOG) begin
				wd_proc <= watchdog_proc_only;
			end
		end
	end

	// Reset lines asserted from the edge the sequencer enters a reset state (the write edge for commands) until it leaves
	always_comb begin
		next_lines = '0;
		unique case (next_state)
			reset_controller_pkg::ST_IDLE: next_lines = '0;
			reset_controller_pkg::ST_SOFT: begin
				if (state == reset_controller_pkg::ST_IDLE) begin
					next_lines.cpu = writedata[`RC_CMD_CPU_BIT];
					next_lines.periph = writedata[`RC_CMD_PERIPH_BIT];
				end else begin
					next_lines = soft_sel;
				end
			end
			reset_controller_pkg::ST_WDOG: begin
				next_lines.cpu = 1'b1;
				next_lines.periph = (state == reset_controller_pkg::ST_WDOG) ?
					!wd_proc : !watchdog_proc_only;
			end
			reset_controller_pkg::ST_BROWN: next_lines = '1;
			reset_controller_pkg::ST_USER: next_lines = '1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			cpu_reset <= 1'b0;
			periph_reset <= 1'b0;
		end else begin
			cpu_reset <= next_lines.cpu;
			periph_reset <= next_lines.periph;
		end
	end

	// External pulse: loaded with 2^(length+1) slow cycles on each trigger
	always_comb begin
		start_ext = 1'b0;
		if (next_state != state) begin
			unique case (next_state)
				reset_controller_pkg::ST_SOFT: start_ext = writedata[`RC_CMD_PIN_BIT];
				reset_controller_pkg::ST_WDOG: start_ext = !watchdog_proc_only;
				reset_controller_pkg::ST_BROWN: start_ext = 1'b1;
				reset_controller_pkg::ST_USER: start_ext = 1'b1;
				reset_controller_pkg::ST_IDLE: start_ext = 1'b0;
			endcase
		end
		if (start_ext) begin
			next_ext_cnt = EXT_W'(1) << ({1'b0, mode.ext_pulse_length} + 5'h1);
		end else if (slow_tick && ext_cnt != '0) begin
			next_ext_cnt = ext_cnt - EXT_W'(1);
		end else begin
			next_ext_cnt = ext_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			ext_cnt <= '0;
			pin_oe_n <= 1'b1;
			pin_out <= 1'b0;
			pin_self <= 1'b0;
		end else begin
			ext_cnt <= next_ext_cnt;
			pin_oe_n <= (next_ext_cnt == '0);
			pin_out <= 1'b0;
			pin_self <= (next_ext_cnt != '0) || (pin_self && !pin_level);
		end
	end

	// Cause of the last processor reset, loaded as the processor line releases
	always_ff @(posedge clk) begin
		if (backup_reset) begin
			cause <= reset_controller_pkg::CAUSE_GENERAL;
		end else if (rst) begin
			cause <= reset_controller_pkg::CAUSE_WAKEUP;
		end else if (next_state == reset_controller_pkg::ST_IDLE && cpu_reset) begin
			unique case (state)
				reset_controller_pkg::ST_SOFT: cause <= reset_controller_pkg::CAUSE_SOFTWARE;
				reset_controller_pkg::ST_WDOG: cause <= reset_controller_pkg::CAUSE_WATCHDOG;
				reset_controller_pkg::ST_BROWN: cause <= reset_controller_pkg::CAUSE_BROWNOUT;
				reset_controller_pkg::ST_USER: cause <= reset_controller_pkg::CAUSE_USER;
				reset_controller_pkg::ST_IDLE: cause <= cause;
			endcase
		end
	end

	// Mode register survives the core reset
	always_ff @(posedge clk) begin
		if (backup_reset) begin
			mode <= `RC_MODE_RESET;
		end else if (wr_acc && address == `RC_MODE_OFS && key_ok) begin
			mode.pin_reset_enable <= writedata[`RC_MD_PIN_EN_BIT];
			mode.pin_fall_irq_enable <= writedata[`RC_MD_PIN_IE_BIT];
			mode.ext_pulse_length <= writedata[`RC_MD_LEN_LSB +: LEN_W];
			mode.brownout_irq_enable <= writedata[`RC_MD_BOD_IE_BIT];
		end
	end

	// Sticky flags cleared by a status read; only bits seen by that read clear
	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			pin_fall_flag <= 1'b0;
			brownout_flag <= 1'b0;
			snap_flags <= 2'h0;
		end else begin
			if (rd_cap && address == `RC_STATUS_OFS) begin
				snap_flags <= {brownout_flag, pin_fall_flag};
			end
			pin_fall_flag <= (pin_fall_flag && !(status_rd && snap_flags[0])) ||
				pin_fall_ev;
			brownout_flag <= (brownout_flag && !(status_rd && snap_flags[1])) ||
				bo_fall_ev;
		end
	end

	// Event status (write one to clear) and its mask
	assign irq_events = {busy && next_state != reset_controller_pkg::ST_SOFT,
		bo_fall_ev, pin_fall_ev};

	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			irq_status <= '0;
			irq_mask <= '0;
		end else begin
			if (wr_acc && address == `RC_IRQ_STATUS_OFS) begin
				irq_status <= (irq_status & ~writedata[`RC_EV_W-1:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
			if (wr_acc && address == `RC_IRQ_MASK_OFS) begin
				irq_mask <= writedata[`RC_EV_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			irq <= 1'b0;
		end else begin
			irq <= (pin_fall_flag && mode.pin_fall_irq_enable && !mode.pin_reset_enable) ||
				(brownout_flag && mode.brownout_irq_enable) ||
				|(irq_status & irq_mask);
		end
	end

	// Read data captured during the wait cycle, standing at the completing edge
	always_comb begin
		next_readdata = 32'h0;
		unique case (address)
			`RC_STATUS_OFS: begin
				next_readdata[`RC_ST_PIN_FALL_BIT] = pin_fall_flag;
				next_readdata[`RC_ST_BROWNOUT_BIT] = brownout_flag;
				next_readdata[`RC_ST_CAUSE_LSB +: 3] = cause;
				next_readdata[`RC_ST_PIN_LEVEL_BIT] = pin_level;
				next_readdata[`RC_ST_BUSY_BIT] = busy;
			end
			`RC_MODE_OFS: begin
				next_readdata[`RC_MD_PIN_EN_BIT] = mode.pin_reset_enable;
				next_readdata[`RC_MD_PIN_IE_BIT] = mode.pin_fall_irq_enable;
				next_readdata[`RC_MD_LEN_LSB +: LEN_W] = mode.ext_pulse_length;
				next_readdata[`RC_MD_BOD_IE_BIT] = mode.brownout_irq_enable;
			end
			`RC_IRQ_STATUS_OFS: next_readdata[`RC_EV_W-1:0] = irq_status;
			`RC_IRQ_MASK_OFS: next_readdata[`RC_EV_W-1:0] = irq_mask;
			default: next_readdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0;
		end else if (rd_cap) begin
			readdata <= next_readdata;
		end
	end

endmodule

// *** include/reset_controller_map.svh ***
/*
 * Register map, field positions, reset values and timing counts of the reset controller.
 * Assumes byte addresses on a 32-bit Avalon-MM slave port.
 */
`ifndef RESET_CONTROLLER_MAP_SVH
`define RESET_CONTROLLER_MAP_SVH

// Register byte offsets
`define RC_CMD_OFS 5'h00
`define RC_STATUS_OFS 5'h04
`define RC_MODE_OFS 5'h08
`define RC_IRQ_STATUS_OFS 5'h0c
`define RC_IRQ_MASK_OFS 5'h10

// Password in the top byte of keyed writes
`define RC_KEY_VALUE 8'ha5
`define RC_KEY_MSB 31
`define RC_KEY_LSB 24

// Command bits
`define RC_CMD_CPU_BIT 0
`define RC_CMD_PERIPH_BIT 2
`define RC_CMD_PIN_BIT 3

// Status fields
`define RC_ST_PIN_FALL_BIT 0
`define RC_ST_BROWNOUT_BIT 1
`define RC_ST_CAUSE_LSB 8
`define RC_ST_PIN_LEVEL_BIT 16
`define RC_ST_BUSY_BIT 17

// Mode fields
`define RC_MD_PIN_EN_BIT 0
`define RC_MD_PIN_IE_BIT 4
`define RC_MD_LEN_LSB 8
`define RC_MD_BOD_IE_BIT 16
`define RC_MODE_RESET 7'h00

// Interrupt event bits (status and mask share the layout)
`define RC_EV_PIN_FALL 0
`define RC_EV_BROWNOUT 1
`define RC_EV_CMD_DONE 2
`define RC_EV_W 3

// Slow-clock cycles that every software and watchdog reset lasts, and that brownout and user resets last after brownout_n or the pin returns high
`define RC_HOLD_SLOW 3

`endif

// *** include/reset_controller_pkg.sv ***
/*
 * Types of the reset controller: sequencer states, reset causes and the mode layout.
 * Assumes the map header supplies every offset and field position.
 */
package reset_controller_pkg;

	// Gray codes along idle -> software -> watchdog -> brownout -> user
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SOFT = 3'h1,
		ST_WDOG = 3'h3,
		ST_BROWN = 3'h2,
		ST_USER = 3'h6
	} seq_state_e;

	typedef enum logic [2:0] {
		CAUSE_GENERAL = 3'h0,
		CAUSE_WAKEUP = 3'h1,
		CAUSE_WATCHDOG = 3'h2,
		CAUSE_SOFTWARE = 3'h3,
		CAUSE_USER = 3'h4,
		CAUSE_BROWNOUT = 3'h5
	} reset_cause_e;

	typedef struct packed {
		logic brownout_irq_enable;
		logic [3:0] ext_pulse_length;
		logic pin_fall_irq_enable;
		logic pin_reset_enable;
	} mode_s;

	typedef struct packed {
		logic cpu;
		logic periph;
	} reset_lines_s;

endpackage

// *** tb/reset_controller_regs_checker.sv ***
/*
 * Checker for the reset controller ports: bus answer timing, keyed commands, reset hold.
 * Assumes one clock domain and that the bench toggles slow_clock well below clk.
 */
`timescale 1ns/1ps
module reset_controller_regs_checker #(
	parameter int ADDR_W = 5
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic backup_reset,
	// Avalon-MM
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Sources and pin
	input wire logic slow_clock,
	input wire logic brownout_n,
	input wire logic watchdog_fault,
	input wire logic pin_in,
	input wire logic pin_oe_n,
	// Reset lines
	input wire logic cpu_reset,
	input wire logic periph_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst || backup_reset);
	logic slow_q;
	logic [2:0] rises;
	logic [2:0] held;
	wire cmd = write && !waitrequest && address == '0 && byteenable == 4'hf;
	wire fires = writedata[31:24] == 8'ha5 && (writedata[3:0] & 4'hd) != 4'h0;
	wire calm = rises == 3'h5 && !cpu_reset && !periph_reset && pin_oe_n;
	wire src_ok = pin_in && brownout_n && !watchdog_fault;
	always_ff @(posedge clk) begin
		slow_q <= slow_clock;
	end
	// Slow edges since the last keyed command, with margin past the busy window
	always_ff @(posedge clk) begin
		if (rst || backup_reset) begin
			rises <= 3'h5;
		end else if (write && !waitrequest && address == '0 && fires) begin
			rises <= 3'h0;
		end else if (rises != 3'h5 && slow_clock && !slow_q) begin
			rises <= rises + 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!cpu_reset) begin
			held <= 3'h0;
		end else if (slow_clock && !slow_q && held != 3'h7) begin
			held <= held + 3'h1;
		end
	end
	sequence s_go;
		cmd && fires && calm && src_ok && $past(src_ok);
	endsequence
	sequence s_stay;
		cmd && !fires && calm && src_ok && $past(src_ok);
	endsequence
	a_wait_one_cycle: assert property ((read || write) && waitrequest
		|=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");
	a_cpu_cmd_rise: assert property (s_go ##0 writedata[0] |-> ##[1:2] cpu_reset)
		else $error("cpu reset missing");
	a_periph_cmd_rise: assert property (s_go ##0 writedata[2] |-> ##[1:2] periph_reset)
		else $error("periph reset missing");
	a_pin_cmd_drive: assert property (s_go ##0 writedata[3] |-> ##[1:2] !pin_oe_n)
		else $error("pin not driven");
	a_cmd_no_stray: assert property (s_go ##0 !writedata[0] ##1 (brownout_n && !watchdog_fault)
		|-> !cpu_reset ##1 !cpu_reset)
		else $error("stray cpu reset");
	a_nokey_ignored: assert property (s_stay |=> !cpu_reset && !periph_reset && pin_oe_n)
		else $error("discarded command acted");
	a_hold_three_slow: assert property ($fell(cpu_reset) |-> held >= 3'h3)
		else $error("reset released early");
	a_status_reserved: assert property (read && !waitrequest && address == ADDR_W'(4)
		|-> (readdata & 32'hfffc_f8fc) == 32'h0)
		else $error("status reserved bits set");
endmodule
bind reset_controller_regs reset_controller_regs_checker #(.ADDR_W(ADDR_W))
	u_reset_controller_regs_checker (
	.clk(clk), .rst(rst), .backup_reset(backup_reset), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .slow_clock(slow_clock), .brownout_n(brownout_n),
	.watchdog_fault(watchdog_fault), .pin_in(pin_in), .pin_oe_n(pin_oe_n),
	.cpu_reset(cpu_reset), .periph_reset(periph_reset));

// *** tb/reset_far_side.sv ***
/*
 * Far side of the reset controller: pulled-up reset pin and free-running slow clock.
 * Assumes clk is the master clock of the controller.
 */
`timescale 1ns/1ps
module reset_far_side #(
	parameter int SLOW_HALF = 4
) (
	// Clock
	input wire logic clk,
	// Pin
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic ext_low,
	output logic pin_in,
	// Slow clock
	output logic slow_clock
);
	int div = 0;
	// Pull-up wins unless a party sinks the pin
	assign pin_in = ext_low ? 1'b0 : (pin_oe_n ? 1'b1 : pin_out);
	initial slow_clock = 1'b0;
	always @(posedge clk) begin
		div <= (div == SLOW_HALF - 1) ? 0 : div + 1;
		if (div == SLOW_HALF - 1) begin
			slow_clock <= !slow_clock;
		end
	end
endmodule

// *** tb/tb_reset_controller_regs.sv ***
/*
 * Bench for the reset controller: bus tasks, commands, flags, interrupt and reset causes.
 * Assumes the far-side model supplies the slow clock and the resolved pin.
 */
`timescale 1ns/1ps
module tb_reset_controller_regs;
	logic clk, rst, backup_reset, read, write, waitrequest, slow_clock, brownout_n, sq;
	logic bod_reset_enable, watchdog_fault, watchdog_proc_only, ext_low, irq;
	logic pin_in, pin_out, pin_oe_n, cpu_reset, periph_reset;
	logic [4:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, s;
	logic [3:0] cmds [4];
	logic [2:0] cause;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	reset_controller_regs u_reset_controller_regs (.clk(clk), .rst(rst),
		.backup_reset(backup_reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .slow_clock(slow_clock), .brownout_n(brownout_n),
		.bod_reset_enable(bod_reset_enable), .watchdog_fault(watchdog_fault),
		.watchdog_proc_only(watchdog_proc_only), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .cpu_reset(cpu_reset), .periph_reset(periph_reset), .irq(irq));
	reset_far_side u_reset_far_side (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_low(ext_low), .pin_in(pin_in), .slow_clock(slow_clock));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task complete_run;
		$display("TB counts: %0d mismatches in %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task timeout;
		err_total++;
		$display("BAD %0t wait ran out", $time);
		complete_run;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		s = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (k >= 50) timeout;
	endtask
	task wcpu(input logic v);
		int k;
		k = 0;
		while (cpu_reset !== v && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000) timeout;
	endtask
	task idle_wait;
		int k;
		k = 0;
		do begin
			bus(1'b0, 5'h04, 32'h0);
			k++;
		end while (s[17] !== 1'b0 && k < 100);
		if (k >= 100) timeout;
		repeat (48) @(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		backup_reset = 1'b1;
		{read, write, watchdog_fault, watchdog_proc_only, ext_low, bod_reset_enable} = 6'h0;
		address = 5'h0;
		writedata = 32'h0;
		byteenable = 4'hf;
		brownout_n = 1'b1;
		cmds = '{4'h1, 4'h4, 4'h8, 4'hd};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		backup_reset <= 1'b0;
		bus(1'b0, 5'h04, 32'h0); chk(s, 32'h0001_0000);
		bus(1'b0, 5'h08, 32'h0); chk(s, 32'h0);
		bus(1'b1, 5'h08, 32'h5a01_0f11);
		bus(1'b0, 5'h08, 32'h0); chk(s, 32'h0);
		bus(1'b1, 5'h14, 32'hffff_ffff);
		bus(1'b0, 5'h14, 32'h0); chk(s, 32'h0);
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 5'h04, 32'h0); chk(s, 32'h0001_0100);
		bus(1'b1, 5'h08, 32'ha500_0001);
		bus(1'b1, 5'h00, 32'h5a00_000d);
		repeat (3) @(posedge clk);
		#1 chk({cpu_reset, periph_reset, pin_oe_n}, 3'h1);
		bus(1'b1, 5'h00, 32'ha500_0000);
		repeat (3) @(posedge clk);
		#1 chk({cpu_reset, periph_reset, pin_oe_n}, 3'h1);
		bus(1'b0, 5'h04, 32'h0); chk(s[17], 1'h0);
		cause = 3'h1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 5'h00, {8'ha5, 20'h0, cmds[i]});
			repeat (2) @(posedge clk);
			#1 chk({!pin_oe_n, periph_reset, 1'b0, cpu_reset}, cmds[i]);
			chk({pin_out, pin_in}, {1'b0, !cmds[i][3]});
			bus(1'b0, 5'h04, 32'h0); chk(s[17], 1'h1);
			bus(1'b1, 5'h00, 32'ha500_000d);
			repeat (2) @(posedge clk);
			#1 chk(periph_reset, cmds[i][2]);
			idle_wait;
			if (cmds[i][0]) cause = 3'h3;
			bus(1'b0, 5'h04, 32'h0); chk({cpu_reset, s[10:8]}, {1'h0, cause});
		end
		bus(1'b1, 5'h08, 32'ha500_0201);
		bus(1'b1, 5'h00, 32'ha500_0008);
		n = 0;
		sq = slow_clock;
		for (int k = 0; k < 3000 && (k < 4 || pin_oe_n === 1'b0); k++) begin
			@(posedge clk);
			if (pin_oe_n === 1'b0 && slow_clock && !sq) n++;
			sq = slow_clock;
		end
		chk(n, 32'h8);
		idle_wait;
		bus(1'b1, 5'h0c, 32'h7);
		bus(1'b1, 5'h08, 32'ha501_0010);
		bus(1'b0, 5'h04, 32'h0);
		ext_low <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({irq, cpu_reset}, 2'h2);
		bus(1'b0, 5'h04, 32'h0); chk(s & 32'h0003_0003, 32'h1);
		ext_low <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'h0);
		@(posedge clk) brownout_n <= 1'b0;
		repeat (4) @(posedge clk) brownout_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(irq, 1'h1);
		bus(1'b0, 5'h04, 32'h0); chk(s & 32'h0000_0703, 32'h0000_0302);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'h0);
		bus(1'b1, 5'h08, 32'ha500_0000);
		@(posedge clk) brownout_n <= 1'b0;
		repeat (4) @(posedge clk) brownout_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(irq, 1'h0);
		bus(1'b1, 5'h10, 32'h2);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'h1);
		bus(1'b0, 5'h0c, 32'h0); chk(s[2:0], 3'h3);
		bus(1'b1, 5'h0c, 32'h3);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'h0);
		bus(1'b1, 5'h08, 32'ha500_0001);
		ext_low <= 1'b1;
		wcpu(1'b1);
		repeat (2) @(posedge clk);
		#1 chk(periph_reset, 1'h1);
		@(posedge clk) ext_low <= 1'b0;
		wcpu(1'b0);
		idle_wait;
		bus(1'b0, 5'h04, 32'h0); chk(s[10:8], 3'h4);
		bus(1'b1, 5'h00, 32'ha500_0001);
		repeat (4) @(posedge clk);
		watchdog_fault <= 1'b1;
		watchdog_proc_only <= 1'b1;
		@(posedge clk) watchdog_fault <= 1'b0;
		wcpu(1'b0);
		idle_wait;
		bus(1'b0, 5'h04, 32'h0); chk({periph_reset, s[10:8]}, 4'h2);
		bod_reset_enable <= 1'b1;
		brownout_n <= 1'b0;
		wcpu(1'b1);
		repeat (2) @(posedge clk);
		#1 chk({periph_reset, pin_oe_n}, 2'h2);
		@(posedge clk) brownout_n <= 1'b1;
		wcpu(1'b0);
		idle_wait;
		bus(1'b0, 5'h04, 32'h0); chk(s[10:8], 3'h5);
		complete_run;
	end
endmodule
